// ---- sar_adc_map.svh ----
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH

// Result width and code span
`define RESULT_BITS 12
`define CODE_STEPS 4096
// Conversion time per grade in ns, slow, middle and fast
`define CONVERT_TIME_SLOW_NS 8000
`define CONVERT_TIME_MID_NS 3000
`define CONVERT_TIME_FAST_NS 1500
// System clock period in ns
`define CLK_PERIOD_NS 10
// Conversion cycle counts, a longest time, so rounded down
`define CONVERT_CYCLES_SLOW (`CONVERT_TIME_SLOW_NS / `CLK_PERIOD_NS)
`define CONVERT_CYCLES_MID (`CONVERT_TIME_MID_NS / `CLK_PERIOD_NS)
`define CONVERT_CYCLES_FAST (`CONVERT_TIME_FAST_NS / `CLK_PERIOD_NS)
// Grade codes
`define GRADE_SLOW 2'h0
`define GRADE_MID 2'h1
`define GRADE_FAST 2'h2
// Timer and bit counter widths
`define TIMER_W 10
`define BITCNT_W 4
// Reset values
`define RESULT_RESET 12'h000
`define SAMPLE_RESET 12'h000

`endif

// ---- sar_adc_pkg.sv ----
package sar_adc_pkg;

  typedef enum logic [1:0] {
    ST_ACQUIRE = 2'b00,
    ST_CONVERT = 2'b01,
    ST_SLEEP = 2'b10
  } adc_state_t;

  // Synchronised link pins
  typedef struct packed {
    logic strobe;
    logic sck;
  } link_in_t;

  // Serial output pin as driven
  typedef struct packed {
    logic data;
    logic oe;
  } link_out_t;

endpackage

// ---- sar_sync2.sv ----
`timescale 1ns/10ps
// Two-flop synchroniser for one pin; stage one is read by stage two only
module sar_sync2
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  // Pin level
  input wire logic i_pin,
  output logic o_level
);

  typedef struct packed {
    logic meta;
    logic level;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // Shift the pin through both stages
  always_comb
  begin
    next_st = st;
    if (i_ce)
    begin
      next_st.meta = i_pin;
      next_st.level = st.meta;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign o_level = st.level;

endmodule // sar_sync2

// ---- sar_adc_serial_readout.sv ----
`timescale 1ns/10ps
`include "sar_adc_map.svh"
// Contract
// R1 - A rising convert_strobe starts converting the held sample and floats serial_result_out.
// R2 - When conversion ends with the strobe still high the device sleeps with bias off.
// R3 - A falling convert_strobe enables serial_result_out and presents result_top_bit at once.
// R4 - Each falling shift clock edge moves out the next bit; the host samples on the rising edge.
// R5 - After twelve bits, further falling shift clock edges with the strobe low give zeros.
// R6 - Sample-and-hold stays in hold during sleep and returns to sampling after the strobe falls.
// R7 - A low strobe wakes the device and starts acquisition; host waits acquisition_interval.
// R8 - Conversion is timed internally, independent of the shift clock, for three grade rates.
// R9 - The host should hold the shift clock static while a conversion runs.
// R10 - The host holds the strobe high for at least 8, 3 or 1.5 us by grade.
// R11 - A frame is the twelve result bits, most significant first, then only zeros.
// R12 - The result is straight binary, one step being full scale over 4096.
// R13 - serial_result_out floats while the strobe is high and is driven only while it is low.
module sar_adc_serial_readout
  import sar_adc_pkg::*;
(
  // Clock, reset and enable
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  // Grade select, static
  input wire logic [1:0] i_grade,
  // Converter core: quantised code of the held sample
  input wire logic [`RESULT_BITS-1:0] i_sample_code,
  // Link pins from the host
  input wire logic i_convert_strobe,
  input wire logic i_shift_clk,
  // Serial result pin
  output logic o_serial_result_out,
  output logic o_serial_result_out_oe,
  // Analog core controls
  output logic o_sampling,
  output logic o_bias_on,
  output logic o_converting
);

  typedef struct packed {
    adc_state_t state;
    logic strobe_d;
    logic sck_d;
    logic [`TIMER_W-1:0] timer;
    logic [`RESULT_BITS-1:0] shreg;
    logic [`BITCNT_W-1:0] bits_left;
    link_out_t pin;
    logic sampling;
    logic bias_on;
    logic converting;
  } core_state_t;

  core_state_t st;
  core_state_t next_st;
  link_in_t lin;
  logic strobe_rise;
  logic strobe_fall;
  logic sck_fall;
  logic [`TIMER_W-1:0] convert_len;

  // Both pins are asynchronous to i_clk, so each passes two flops first
  sar_sync2 u_sync_convert_strobe
  (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_pin(i_convert_strobe),
    .o_level(lin.strobe)
  );

  sar_sync2 u_sync_sck
  (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_pin(i_shift_clk),
    .o_level(lin.sck)
  );

  // Edge detection on synchronised levels only
  assign strobe_rise = lin.strobe && !st.strobe_d;
  assign strobe_fall = !lin.strobe && st.strobe_d;
  assign sck_fall = !lin.sck && st.sck_d;

  // Conversion length by grade; the shift clock plays no part here
  always_comb
  begin
    if (i_grade == `GRADE_SLOW)
      convert_len = `TIMER_W'(`CONVERT_CYCLES_SLOW); // see R8
    else if (i_grade == `GRADE_MID)
      convert_len = `TIMER_W'(`CONVERT_CYCLES_MID);
    else
      convert_len = `TIMER_W'(`CONVERT_CYCLES_FAST);
  end

  // Whole next state
  always_comb
  begin
    next_st = st;
    if (i_ce)
    begin
      next_st.strobe_d = lin.strobe;
      next_st.sck_d = lin.sck;
      case (st.state)
        ST_ACQUIRE:
        begin
          next_st.sampling = 1'b1;
          next_st.bias_on = 1'b1;
          if (strobe_rise)
          begin
            // Freeze sample and float the pin at once
            next_st.state = ST_CONVERT; // see R1
            next_st.sampling = 1'b0;
            next_st.converting = 1'b1;
            next_st.timer = convert_len - `TIMER_W'(1);
            next_st.pin.oe = 1'b0; // see R13
            next_st.pin.data = 1'b0;
          end
        end
        ST_CONVERT:
        begin
          if (st.timer != '0)
            next_st.timer = st.timer - `TIMER_W'(1);
          else
          begin
            // Straight binary code from the core, no recoding
            next_st.shreg = i_sample_code; // see R12
            next_st.converting = 1'b0;
            next_st.state = ST_SLEEP;
            next_st.bias_on = 1'b0; // see R2
          end
        end
        ST_SLEEP:
        begin
          // Hold stays on; wake only when the strobe drops
          next_st.sampling = 1'b0; // see R6
          next_st.bias_on = 1'b0;
          if (strobe_fall)
          begin
            next_st.state = ST_ACQUIRE; // see R7
            next_st.sampling = 1'b1;
            next_st.bias_on = 1'b1;
            next_st.pin.oe = 1'b1; // see R3
            next_st.pin.data = st.shreg[`RESULT_BITS-1];
            next_st.shreg = {st.shreg[`RESULT_BITS-2:0], 1'b0};
            next_st.bits_left = `BITCNT_W'(`RESULT_BITS - 1);
          end
        end
        default:
        begin
          next_st.state = ST_ACQUIRE;
        end
      endcase
      // Shifting while driving; shreg back-fills zeros so the tail is zero
      if (st.state == ST_ACQUIRE && st.pin.oe && !strobe_rise && sck_fall)
      begin
        next_st.pin.data = st.shreg[`RESULT_BITS-1]; // see R4
        next_st.shreg = {st.shreg[`RESULT_BITS-2:0], 1'b0}; // see R11
        if (st.bits_left != '0)
          next_st.bits_left = st.bits_left - `BITCNT_W'(1);
        else
          next_st.pin.data = 1'b0; // see R5
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st <= '0;
      st.state <= ST_SLEEP;
      st.shreg <= `RESULT_RESET;
    end
    else
      st <= next_st;
  end

  // Outputs straight from flops
  assign o_serial_result_out = st.pin.data;
  assign o_serial_result_out_oe = st.pin.oe;
  assign o_sampling = st.sampling;
  assign o_bias_on = st.bias_on;
  assign o_converting = st.converting;

  property p_float_on_rise;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && st.state == ST_ACQUIRE && strobe_rise) |=> !o_serial_result_out_oe;
  endproperty
  a_float_on_rise: assert property (p_float_on_rise) else $error("pin not floated"); // see R1

  property p_sleep_after;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && st.state == ST_CONVERT && st.timer == '0) |=> (st.state == ST_SLEEP && !o_bias_on);
  endproperty
  a_sleep_after: assert property (p_sleep_after) else $error("no sleep after convert"); // see R2

  property p_msb_first;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && st.state == ST_SLEEP && strobe_fall)
      |=> (o_serial_result_out_oe && o_serial_result_out == $past(st.shreg[`RESULT_BITS-1]));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("top bit not presented"); // see R3

  property p_zero_tail;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && o_serial_result_out_oe && st.bits_left == '0 && sck_fall && !strobe_rise)
      |=> !o_serial_result_out;
  endproperty
  a_zero_tail: assert property (p_zero_tail) else $error("tail bit not zero"); // see R5

  property p_hold_in_sleep;
    @(posedge i_clk) disable iff (!i_reset_n)
    (st.state == ST_SLEEP) |-> (!o_sampling && !o_bias_on);
  endproperty
  a_hold_in_sleep: assert property (p_hold_in_sleep) else $error("sampling in sleep"); // see R6

  property p_wake;
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_ce && st.state == ST_SLEEP && strobe_fall) |=> (o_sampling && o_bias_on);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on fall"); // see R7

  sequence s_convert_start;
    i_ce && st.state == ST_ACQUIRE && strobe_rise && i_grade == `GRADE_FAST;
  endsequence
  property p_fast_len;
    @(posedge i_clk) disable iff (!i_reset_n)
    (s_convert_start ##1 (i_ce && i_grade == `GRADE_FAST) [*8]) |-> o_converting;
  endproperty
  a_fast_len: assert property (p_fast_len) else $error("conversion ended early"); // see R8

  property p_float_high;
    @(posedge i_clk) disable iff (!i_reset_n)
    (st.state == ST_CONVERT || st.state == ST_SLEEP) |-> !o_serial_result_out_oe;
  endproperty
  a_float_high: assert property (p_float_high) else $error("pin driven while high"); // see R13

endmodule // sar_adc_serial_readout

// ---- sar_host_model.sv ----
`timescale 1ns/10ps
// Host side of the link: drives strobe and shift clock, samples on the rise
module sar_host_model
(
  // Clock
  input wire logic i_clk,
  // Serial result pin as driven
  input wire logic i_data,
  input wire logic i_data_oe,
  // Link pins to the device
  output logic o_strobe,
  output logic o_sck
);
  logic last = 1'b0;
  logic line;

  // A released pin shows the inverse of its last level, so stale data cannot pass
  always @(posedge i_clk)
    if (i_data_oe) last <= i_data;
  assign line = i_data_oe ? i_data : ~last;

  // Strobe starts high so the first fall is seen; shift clock idles low
  initial
  begin
    o_strobe = 1'b1;
    o_sck = 1'b0;
  end

  // Raise strobe only after acquisition; the caller holds it past conversion
  task automatic start();
    @(negedge i_clk) o_strobe = 1'b1;
  endtask

  // One 160 ns shift clock period
  task automatic pulse(output logic bit_in);
    o_sck = 1'b1;
    bit_in = line;
    repeat (8) @(negedge i_clk);
    o_sck = 1'b0;
    repeat (8) @(negedge i_clk);
  endtask

  // Lower strobe, then clock in sixteen bits; shift clock is quiet otherwise
  task automatic read(output logic [15:0] word);
    logic b;
    word = 16'h0000;
    @(negedge i_clk) o_strobe = 1'b0;
    repeat (8) @(negedge i_clk);
    for (int k = 0; k < 16; k++)
    begin
      pulse(b);
      word = {word[14:0], b};
    end
  endtask
endmodule // sar_host_model

// ---- sar_adc_serial_readout_tb.sv ----
`timescale 1ns/10ps
`include "sar_adc_map.svh"
module sar_adc_serial_readout_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] grade = 2'h0;
  logic [11:0] code = 12'h000;
  logic strobe, sck, dout, oe, sampling, bias, converting;
  int failures = 0;
  int cmp_count = 0;

  always #5 clk = ~clk;

  sar_adc_serial_readout i_dut (.i_clk(clk), .i_reset_n(reset_n), .i_ce(1'b1),
    .i_grade(grade), .i_sample_code(code), .i_convert_strobe(strobe),
    .i_shift_clk(sck), .o_serial_result_out(dout), .o_serial_result_out_oe(oe),
    .o_sampling(sampling), .o_bias_on(bias), .o_converting(converting));

  sar_host_model host (.i_clk(clk), .i_data(dout), .i_data_oe(oe), .o_strobe(strobe),
    .o_sck(sck));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One conversion and readout; tick clocks the link while the device sleeps
  task automatic t_frame(input logic [1:0] g, input logic [11:0] c, input int len,
                         input bit tick);
    int n;
    logic b;
    logic [15:0] w;
    n = 0;
    grade = g;
    code = c;
    repeat (200) @(negedge clk);
    host.start();
    repeat (6) @(negedge clk);
    check(oe, 1'b0);
    check(converting, 1'b1);
    check(sampling, 1'b0);
    while (converting === 1'b1 && n < 1000)
    begin
      @(negedge clk);
      n++;
      if (oe !== 1'b0) check(oe, 1'b0);
    end
    // Timer is internal, so the length must follow the grade alone
    check(n >= len - 6 && n <= len, 1'b1);
    code = ~c;
    repeat (4) @(negedge clk);
    check(bias, 1'b0);
    check(sampling, 1'b0);
    if (tick)
      repeat (3) host.pulse(b);
    check(oe, 1'b0);
    host.read(w);
    check(w, {c, 4'h0});
    check({oe, sampling, bias}, 3'h7);
  endtask

  // First fall after reset wakes the device and reads the reset result
  task automatic t_wake();
    logic [15:0] w;
    host.read(w);
    check(w, {`RESULT_RESET, 4'h0});
  endtask

  initial
  begin
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    // Asleep after reset: pin floated, hold on, bias off, no conversion
    check({oe, dout, sampling, bias, converting}, 5'h00);
    t_wake();
    t_frame(`GRADE_SLOW, 12'hA5C, `CONVERT_CYCLES_SLOW, 1'b0);
    t_frame(`GRADE_MID, 12'h3A1, `CONVERT_CYCLES_MID, 1'b0);
    t_frame(`GRADE_FAST, 12'hFFF, `CONVERT_CYCLES_FAST, 1'b1);
    t_frame(2'h3, 12'h801, `CONVERT_CYCLES_FAST, 1'b0);
    give_verdict();
  end

  // Whole run is about 36 us; over five times that means a hang
  initial
  begin
    #200000;
    failures++;
    give_verdict();
  end
endmodule // sar_adc_serial_readout_tb
